// *** sdrce_engine.sv ***
// Purpose: SDRAM read/write cycle engine for SDR and DDR memories
// Assumes: Memory clock arrives as a pin and is sampled by clk_sys
// Notes:   Write data is buffered; a write command waits for its words
//
// How it works
// - Accesses only while command mode is zero
// - Open row remembered per bank
// - Every command is a burst of eight
// - DDR write data one clock late; SDR none
// - Open row hit writes without precharge
// - Miss: precharge if the bank has a row open, wait, activate, wait, write
// - SDR single write ends with burst stop
// - DDR single write masks unused beats, strobe toggles
// - Non-sequential write forces a new page open
// - Block by addr[13:3], start by addr[2:0]
// - Block-crossing write split into two commands
// - Second write command masks unrequested beats on DDR, ends with burst stop on SDR
// - Read waits six cycles after a write
// - Mask raised before a read cuts a write
// - Wait CAS latency after each read
// - Read hit direct, miss opens page first
// - Short read ends with burst stop
// - Non-sequential read on open page reads directly
// - Unspecified bursts prefetch latency-many extra words
// - Specified bursts no prefetch; remainder becomes unspecified
// - Block-crossing read split into two commands
// - Burst stop trims surplus of second read
// - Refresh waits for the burst in progress
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sdrce_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Filling side
  input  wire logic                       in_valid,
  input  wire logic [W-1:0]               in_data,
  output      logic                       in_ready,
  // Draining side
  output      logic                       out_valid,
  output      logic [W-1:0]               out_data,
  input  wire logic                       out_ready,
  output      logic [$clog2(DEPTH):0]     level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_reg;
  logic [AW:0]   rp_reg;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign level     = wp_reg - rp_reg;
  assign in_ready  = level != DEPTH[AW:0];
  assign out_valid = level != '0;
  assign out_data  = mem[rp_reg[AW-1:0]];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop)  rp_reg <= rp_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule : sdrce_fifo

////////////////////////////////////////////////////////////////////////////////
module sdrce_engine
  import sdrce_pkg::*;
#(
  parameter int DATA_W  = 32,
  parameter int BANKS   = 4,
  parameter int FIFO_D  = 8
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // Configuration levels
  input  wire logic [2:0]           cmd_mode_field,
  input  wire logic                 mem_is_ddr,
  input  wire logic [1:0]           cas_latency,
  input  wire logic                 cas_half,
  input  wire logic [3:0]           t_rp,
  input  wire logic [3:0]           t_rcd,
  // Access requests
  input  wire logic                 req_valid,
  input  wire sdrce_req_t           req,
  output      logic                 req_ready,
  output      logic                 busy,
  // Write data
  input  wire logic                 wdata_valid,
  input  wire logic [DATA_W-1:0]    wdata,
  output      logic                 wdata_ready,
  // Read data
  output      logic                 rdata_valid,
  output      logic [DATA_W-1:0]    rdata,
  // Refresh
  input  wire logic                 refresh_req,
  output      logic                 refresh_done,
  // Memory link
  input  wire logic                 link_clk,
  output      sdrce_pins_t          mem_pins,
  input  wire logic [DATA_W-1:0]    dq_i,
  output      logic [DATA_W-1:0]    dq_o,
  output      logic                 dq_oe,
  output      logic                 dqs_o,
  output      logic                 dqs_oe
);

  //////////////////////////////////////////////////////////////////////////////
  // Link clock sampling; one step per rising edge
  logic [2:0]        lclk_sync_reg;
  logic [DATA_W-1:0] dq_s1_reg;
  logic [DATA_W-1:0] dq_s2_reg;
  wire               tick = lclk_sync_reg[1] && !lclk_sync_reg[2];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lclk_sync_reg <= '0;
      dq_s1_reg     <= '0;
      dq_s2_reg     <= '0;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], link_clk};
      dq_s1_reg     <= dq_i;
      dq_s2_reg     <= dq_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write data buffer
  logic                     fifo_valid;
  logic [DATA_W-1:0]        fifo_data;
  logic                     fifo_pop;
  logic [$clog2(FIFO_D):0]  fifo_level;

  sdrce_fifo #(.W(DATA_W), .DEPTH(FIFO_D)) u_wbuf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (wdata_valid),
    .in_data   (wdata),
    .in_ready  (wdata_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State
  sdrce_state_t       state_reg, state_next;
  sdrce_req_t         cur_reg, cur_next;
  logic [3:0]         tcnt_reg, tcnt_next;
  logic [3:0]         beat_reg, beat_next;
  logic [3:0]         wtr_reg, wtr_next;
  logic               ref_pend_reg, ref_pend_next;
  logic [BANKS-1:0]   open_vld_reg;
  logic [ROW_W-1:0]   open_row_reg [BANKS];
  sdrce_pins_t        pins_reg, pins_next;
  logic [DATA_W-1:0]  dq_o_reg, dq_o_next;
  logic               dq_oe_reg, dq_oe_next;
  logic               dqs_reg, dqs_next;
  logic               dqs_oe_reg, dqs_oe_next;
  logic [DATA_W-1:0]  rdata_reg, rdata_next;
  logic               rvalid_reg, rvalid_next;
  logic               refdone_reg, refdone_next;
  logic               open_set, open_clr;

  // Decode of the current access
  wire [BANK_W-1:0] bank   = cur_reg.addr[BANK_LSB +: BANK_W];
  wire [ROW_W-1:0]  row    = cur_reg.addr[ROW_LSB +: ROW_W];
  wire [COL_W-1:0]  col    = {cur_reg.addr[BLK_MSB:BLK_LSB], cur_reg.addr[2:0]};
  // Split points follow memory type
  wire [3:0]        wpc    = mem_is_ddr ? DDR_WORDS : SDR_WORDS;
  wire [2:0]        off_w  = mem_is_ddr ? {1'b0, cur_reg.addr[3:2]} : cur_reg.addr[4:2];
  wire [3:0]        room   = wpc - {1'b0, off_w};
  // Words this command serves; rest goes to a second command
  wire [3:0]        chunk  = (cur_reg.beats > {1'b0, room}) ? room
                                                            : cur_reg.beats[3:0];
  wire [3:0]        cl     = {2'b00, cas_latency} + {3'b000, cas_half};
  wire [3:0]        pref   = chunk + cl;
  wire [3:0]        rd_n   = !cur_reg.unspec ? chunk
                           : (pref > room) ? room : pref;
  wire              hit    = open_vld_reg[bank] && (open_row_reg[bank] == row);
  wire              wr_brk = cur_reg.write && !cur_reg.seq;
  wire              go_cmd = hit && !wr_brk;
  wire              mode_ok = cmd_mode_field == MODE_NORMAL;
  wire              rd_blk = !cur_reg.write && (wtr_reg != '0);
  wire              wr_rdy = fifo_level >= {1'b0, chunk};
  wire [4:0]        rem    = cur_reg.beats - {1'b0, chunk};
  wire [31:0]       nxt_a  = cur_reg.addr + {26'h0, chunk, 2'b00};
  wire              beat_use = beat_reg < chunk;

  assign req_ready    = (state_reg == S_IDLE) && tick && !ref_pend_reg && mode_ok;
  assign busy         = (state_reg != S_IDLE) || ref_pend_reg;
  assign fifo_pop     = tick && ((state_reg == S_WDATA && beat_use)
                      || (state_reg == S_CMD && cur_reg.write && !mem_is_ddr && wr_rdy));
  assign mem_pins     = pins_reg;
  assign dq_o         = dq_o_reg;
  assign dq_oe        = dq_oe_reg;
  assign dqs_o        = dqs_reg;
  assign dqs_oe       = dqs_oe_reg;
  assign rdata        = rdata_reg;
  assign rdata_valid  = rvalid_reg;
  assign refresh_done = refdone_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_next    = state_reg;
    cur_next      = cur_reg;
    tcnt_next     = tcnt_reg;
    beat_next     = beat_reg;
    wtr_next      = wtr_reg;
    ref_pend_next = ref_pend_reg || refresh_req;
    pins_next     = pins_reg;
    dq_o_next     = dq_o_reg;
    dq_oe_next    = dq_oe_reg;
    dqs_next      = dqs_reg;
    dqs_oe_next   = dqs_oe_reg;
    rdata_next    = rdata_reg;
    rvalid_next   = 1'b0;
    refdone_next  = 1'b0;
    open_set      = 1'b0;
    open_clr      = 1'b0;
    if (tick) begin
      pins_next     = '{cmd: CMD_NOP, ba: bank, a: col, dm: 1'b0};
      dq_oe_next    = 1'b0;
      dqs_oe_next   = 1'b0;
      if (wtr_reg != '0) wtr_next = wtr_reg - 1'b1;
      case (state_reg)
        S_IDLE: begin
          if (ref_pend_reg) begin
            pins_next.cmd = CMD_REF;
            ref_pend_next = refresh_req;
            refdone_next  = 1'b1;
          end else if (req_valid && mode_ok) begin
            cur_next   = req;
            state_next = S_CHECK;
          end
        end
        S_CHECK: begin
          // Trailing write still masked while the read waits
          pins_next.dm = rd_blk;
          if (!rd_blk) begin
            if (go_cmd)                state_next = S_CMD;
            else if (open_vld_reg[bank]) state_next = S_PRE;
            else                       state_next = S_ACT;
          end
        end
        S_PRE: begin
          pins_next.cmd = CMD_PRE;
          open_clr      = 1'b1;
          tcnt_next     = t_rp;
          state_next    = S_TRP;
        end
        S_TRP: begin
          if (tcnt_reg <= 4'h1) state_next = S_ACT;
          else                  tcnt_next  = tcnt_reg - 1'b1;
        end
        S_ACT: begin
          pins_next.cmd = CMD_ACT;
          pins_next.a   = {{(COL_W-ROW_W){1'b0}}, row};
          open_set      = 1'b1;
          tcnt_next     = t_rcd;
          state_next    = S_TRCD;
        end
        S_TRCD: begin
          if (tcnt_reg <= 4'h1) state_next = S_CMD;
          else                  tcnt_next  = tcnt_reg - 1'b1;
        end
        S_CMD: begin
          beat_next = '0;
          if (!cur_reg.write) begin
            pins_next.cmd = CMD_RD;
            tcnt_next     = cl;
            state_next    = S_CAS;
          end else if (wr_rdy) begin
            // Burst only starts once all its words are buffered
            pins_next.cmd = CMD_WR;
            state_next    = S_WDATA;
            if (!mem_is_ddr) begin
              dq_o_next  = fifo_data;
              dq_oe_next = 1'b1;
              beat_next  = 4'h1;
            end
          end
        end
        S_WDATA: begin
          dq_oe_next = 1'b1;
          beat_next  = beat_reg + 1'b1;
          if (beat_use) dq_o_next = fifo_data;
          if (mem_is_ddr) begin
            dqs_oe_next  = 1'b1;
            dqs_next     = !dqs_reg;
            pins_next.dm = !beat_use;
          end
          if ((!mem_is_ddr && !beat_use) || (beat_reg == BURST_LEN - 1'b1)) begin
            dq_oe_next = mem_is_ddr || beat_use;
            if (!mem_is_ddr && !beat_use) begin
              pins_next.cmd = CMD_BST;
              dq_oe_next    = 1'b0;
            end
            wtr_next = WTR_CYC;
            cur_next.beats  = rem;
            cur_next.addr   = nxt_a;
            cur_next.seq    = 1'b1;
            state_next = (rem != '0) ? S_CHECK : S_IDLE;
          end
        end
        S_CAS: begin
          // Latency counted from the read command
          beat_next = beat_reg + 1'b1;
          if (beat_reg == rd_n && rd_n < BURST_LEN) pins_next.cmd = CMD_BST;
          if (tcnt_reg <= 4'h1) begin
            tcnt_next  = '0;
            state_next = S_RDATA;
          end else begin
            tcnt_next  = tcnt_reg - 1'b1;
          end
        end
        S_RDATA: begin
          beat_next   = beat_reg + 1'b1;
          tcnt_next   = tcnt_reg + 1'b1;
          rdata_next  = dq_s2_reg;
          rvalid_next = 1'b1;
          if (beat_reg == rd_n && rd_n < BURST_LEN) pins_next.cmd = CMD_BST;
          if (tcnt_reg == rd_n - 1'b1) begin
            cur_next.beats  = rem;
            cur_next.addr   = nxt_a;
            cur_next.seq    = 1'b1;
            cur_next.unspec = 1'b1;
            state_next = (rem != '0) ? S_CHECK : S_IDLE;
          end
        end
        default: state_next = S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= S_IDLE;
      cur_reg      <= '0;
      tcnt_reg     <= '0;
      beat_reg     <= '0;
      wtr_reg      <= '0;
      ref_pend_reg <= 1'b0;
      pins_reg     <= '{cmd: CMD_NOP, ba: '0, a: '0, dm: 1'b0};
      dq_o_reg     <= '0;
      dq_oe_reg    <= 1'b0;
      dqs_reg      <= 1'b0;
      dqs_oe_reg   <= 1'b0;
      rdata_reg    <= '0;
      rvalid_reg   <= 1'b0;
      refdone_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cur_reg      <= cur_next;
      tcnt_reg     <= tcnt_next;
      beat_reg     <= beat_next;
      wtr_reg      <= wtr_next;
      ref_pend_reg <= ref_pend_next;
      pins_reg     <= pins_next;
      dq_o_reg     <= dq_o_next;
      dq_oe_reg    <= dq_oe_next;
      dqs_reg      <= dqs_next;
      dqs_oe_reg   <= dqs_oe_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      refdone_reg  <= refdone_next;
    end
  end

  // Open row table, one entry per bank
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      open_vld_reg <= '0;
    end else if (open_set) begin
      open_vld_reg[bank] <= 1'b1;
    end else if (open_clr) begin
      open_vld_reg[bank] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (open_set) open_row_reg[bank] <= row;
  end

endmodule : sdrce_engine

// *** sdrce_pkg.sv ***
// Purpose: Shared constants and types of the SDRAM read/write cycle engine
// Assumes: 32-bit requester words, one command step per memory clock rising edge
// Notes:   Positions, counts and encodings are named here only
package sdrce_pkg;

  // Requester address layout
  localparam int BLK_LSB  = 3;   // 8-column block select addr[13:3]
  localparam int BLK_MSB  = 13;
  localparam int BANK_LSB = 14;
  localparam int BANK_W   = 2;
  localparam int ROW_LSB  = 16;
  localparam int ROW_W    = 13;
  localparam int COL_W    = 14;

  // Memory burst and command timing
  localparam logic [3:0] BURST_LEN    = 4'h8;
  localparam logic [3:0] DDR_WORDS    = 4'h4;   // words per command, DDR
  localparam logic [3:0] SDR_WORDS    = 4'h8;   // words per command, SDR
  localparam logic [3:0] WTR_CYC      = 4'h6;   // BL/2 + 2
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [1:0] CL_MIN       = 2'h2;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_PRE = 3'h4,
    CMD_BST = 3'h5,
    CMD_REF = 3'h6
  } sdrce_cmd_t;

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_CHECK = 4'h1,
    S_PRE   = 4'h2,
    S_TRP   = 4'h3,
    S_ACT   = 4'h4,
    S_TRCD  = 4'h5,
    S_CMD   = 4'h6,
    S_WDATA = 4'h7,
    S_CAS   = 4'h8,
    S_RDATA = 4'h9
  } sdrce_state_t;

  // One requester access descriptor
  typedef struct packed {
    logic        write;
    logic        seq;      // sequential transfer type
    logic        unspec;   // incrementing burst of unspecified length
    logic [4:0]  beats;    // words requested, 1 means single
    logic [31:0] addr;
  } sdrce_req_t;

  // Command pins towards the memory
  typedef struct packed {
    sdrce_cmd_t         cmd;
    logic [BANK_W-1:0]  ba;
    logic [COL_W-1:0]   a;
    logic               dm;
  } sdrce_pins_t;

endpackage : sdrce_pkg

// *** sdrce_checker.sv ***
// Purpose: Port assertions of the SDRAM cycle engine
// Assumes: One clk_sys domain; a link step is about ten clk_sys cycles
// Notes:   Bounds are counted in clk_sys cycles
`timescale 1ns/1ps

module sdrce_checker
  import sdrce_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Observed ports
  input wire logic [2:0]  cmd_mode_field,
  input wire logic        req_valid,
  input wire logic        mem_is_ddr,
  input wire logic        req_ready,
  input wire logic        busy,
  input wire logic        rdata_valid,
  input wire logic        refresh_done,
  input wire sdrce_pins_t mem_pins,
  input wire logic        dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  wire logic is_pre = mem_pins.cmd == CMD_PRE;
  wire logic is_act = mem_pins.cmd == CMD_ACT;
  wire logic is_rd  = mem_pins.cmd == CMD_RD;
  wire logic is_wr  = mem_pins.cmd == CMD_WR;

  // Write recovery: six link steps of at least nine clk_sys cycles each
  localparam logic [7:0] WTR_MIN = 8'h36;
  logic [7:0] since_wd;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) since_wd <= 8'hFF;
    else if (dq_oe) since_wd <= 8'h00;
    else if (since_wd != 8'hFF) since_wd <= since_wd + 8'h01;
  end

  // Precharge time: no activate for four clk_sys cycles after precharge
  sequence s_no_act; (!is_act) [*4]; endsequence
  sequence s_col_cmd; ##[0:300] (is_rd || is_wr); endsequence

  property p_mode; req_ready |-> cmd_mode_field == MODE_NORMAL; endproperty
  property p_busy; req_valid && req_ready |=> busy; endproperty
  property p_ref; refresh_done |-> mem_pins.cmd == CMD_REF; endproperty
  property p_trp; is_pre |=> s_no_act; endproperty
  property p_pre_act; $fell(is_pre) |-> ##[0:200] is_act; endproperty
  property p_act_col; $fell(is_act) |-> s_col_cmd; endproperty
  property p_wtr; $rose(is_rd) |-> since_wd >= WTR_MIN; endproperty
  property p_sdr_wd; $rose(is_wr) && !mem_is_ddr |-> ##[0:1] dq_oe; endproperty
  property p_ddr_wd; $rose(is_wr) && mem_is_ddr && !dq_oe |-> !dq_oe ##[1:25] dq_oe; endproperty
  property p_ddr_bst; mem_pins.cmd == CMD_BST && mem_is_ddr |-> !dq_oe; endproperty
  property p_rd_data; $rose(is_rd) |-> ##[1:400] rdata_valid; endproperty

  a_mode:    assert property (p_mode) else $error("request taken outside normal mode");
  a_busy:    assert property (p_busy) else $error("busy low after request taken");
  a_ref:     assert property (p_ref) else $error("refresh done without refresh command");
  a_trp:     assert property (p_trp) else $error("activate too soon after precharge");
  a_pre_act: assert property (p_pre_act) else $error("no activate after precharge");
  a_act_col: assert property (p_act_col) else $error("no column command after activate");
  a_wtr:     assert property (p_wtr) else $error("read too soon after write");
  a_sdr_wd:  assert property (p_sdr_wd) else $error("SDR write data not with command");
  a_ddr_wd:  assert property (p_ddr_wd) else $error("DDR write data latency wrong");
  a_ddr_bst: assert property (p_ddr_bst) else $error("burst stop during DDR write");
  a_rd_data: assert property (p_rd_data) else $error("no read data after read");
endmodule : sdrce_checker

bind sdrce_engine sdrce_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .cmd_mode_field(cmd_mode_field), .req_valid(req_valid),
  .mem_is_ddr(mem_is_ddr),
  .req_ready(req_ready), .busy(busy), .rdata_valid(rdata_valid),
  .refresh_done(refresh_done), .mem_pins(mem_pins), .dq_oe(dq_oe)
);

// *** sdrce_mem_model.sv ***
// Purpose: Behavioural SDRAM data side for the cycle engine bench
// Assumes: Commands sampled on the memory clock rising edge
// Notes:   Outside a read burst the bus flips every rising edge, never holds
`timescale 1ns/1ps

module sdrce_mem_model
  import sdrce_pkg::*;
#(
  parameter int DATA_W = 32
) (
  // Memory link
  input  wire logic              link_clk,
  input  wire sdrce_pins_t       mem_pins,
  input  wire logic              dq_oe,
  // Data towards the controller
  output      logic [DATA_W-1:0] dq_i
);
  logic [3:0] left = 4'h0;

  initial dq_i = '0;

  always @(posedge link_clk) begin
    if (mem_pins.cmd == CMD_RD) left <= 4'h8;
    else if (mem_pins.cmd == CMD_BST) left <= 4'h0;
    else if (left != 4'h0) left <= left - 4'h1;
    dq_i <= (left != 4'h0 && !dq_oe) ? dq_i + DATA_W'(1) : ~dq_i;
  end
endmodule : sdrce_mem_model

// *** testbench.sv ***
// Purpose: Self-checking bench of the SDRAM cycle engine
// Assumes: Link clock free running, unrelated in phase to clk_sys
// Notes:   Command order is checked per access against a row table
`timescale 1ns/1ps

module testbench;
  import sdrce_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        link_clk = 1'b0;
  logic [2:0]  cmd_mode_field = 3'h0;
  logic        mem_is_ddr = 1'b1;
  logic [1:0]  cas_latency = 2'h2;
  logic        cas_half = 1'b0;
  logic        unspec_q = 1'b0;
  logic [3:0]  t_rp = 4'h2;
  logic [3:0]  t_rcd = 4'h2;
  logic        req_valid = 1'b0;
  sdrce_req_t  req = '0;
  logic        wdata_valid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        refresh_req = 1'b0;
  logic        req_ready, busy, wdata_ready, rdata_valid, refresh_done, dq_oe;
  logic [31:0] rdata, dq_i;
  sdrce_pins_t mem_pins;
  sdrce_cmd_t  prev_cmd = CMD_NOP;
  sdrce_cmd_t  seen[$];
  logic [12:0] open_row[4];
  logic [3:0]  row_ok = 4'h0;
  int          seed = 3, n_mismatch = 0, samples_checked = 0, n_rd = 0, n_ref = 0, pre_n = 0;
  int          settle = 120;

  always #2.5 clk_sys = ~clk_sys;
  always #24 link_clk = ~link_clk;

  sdrce_engine u_dut (
    .clk_sys(clk_sys), .rst(rst), .cmd_mode_field(cmd_mode_field), .mem_is_ddr(mem_is_ddr),
    .cas_latency(cas_latency), .cas_half(cas_half), .t_rp(t_rp), .t_rcd(t_rcd),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .busy(busy),
    .wdata_valid(wdata_valid), .wdata(wdata), .wdata_ready(wdata_ready),
    .rdata_valid(rdata_valid), .rdata(rdata), .refresh_req(refresh_req),
    .refresh_done(refresh_done), .link_clk(link_clk), .mem_pins(mem_pins), .dq_i(dq_i),
    .dq_o(), .dq_oe(dq_oe), .dqs_o(), .dqs_oe()
  );

  sdrce_mem_model u_mem (.link_clk(link_clk), .mem_pins(mem_pins), .dq_oe(dq_oe), .dq_i(dq_i));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    prev_cmd <= mem_pins.cmd;
    if (mem_pins.cmd !== prev_cmd && mem_pins.cmd !== CMD_NOP) seen.push_back(mem_pins.cmd);
    if (rdata_valid === 1'b1) n_rd++;
    if (refresh_done === 1'b1) n_ref++;
  end

  // Commands of one access, first in the low bits
  // A burst crossing its block end takes a second column command
  function automatic logic [20:0] exp_cmds(input logic wr, ddr, sq, hit, opened,
                                           input int beats, input int off, input logic rf);
    logic [20:0] r;
    int k;
    int first;
    int part;
    r = '0;
    k = 0;
    first = (ddr ? int'(DDR_WORDS) : int'(SDR_WORDS)) - off;
    if (first > beats) first = beats;
    if (!(hit && (sq || !wr))) begin
      if (opened) begin r[k*3+:3] = CMD_PRE; k++; end
      r[k*3+:3] = CMD_ACT;
      k++;
    end
    for (int c = 0; c < 2; c++) begin
      part = (c == 0) ? first : beats - first;
      if (part > 0) begin
        r[k*3+:3] = wr ? CMD_WR : CMD_RD;
        k++;
        if (part < 8 && (!wr || !ddr)) begin r[k*3+:3] = CMD_BST; k++; end
      end
    end
    if (rf) r[k*3+:3] = CMD_REF;
    return r;
  endfunction : exp_cmds

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task automatic push_n(input int n);
    if (n > 0) begin
      wdata_valid <= 1'b1;
      for (int i = 0; i < n; i++) begin
        wdata <= $random(seed);
        do @(posedge clk_sys); while (wdata_ready !== 1'b1);
      end
      wdata_valid <= 1'b0;
    end
  endtask : push_n

  task automatic access(input logic wr, sq, ddr, input logic [1:0] bk, input logic [12:0] row,
                        input logic [13:0] col, input int beats, input logic rf);
    logic [20:0] e;
    logic [20:0] g;
    int t;
    int off;
    int n_exp;
    off = ddr ? int'(col[3:2]) : int'(col[4:2]);
    // Unspecified bursts fetch latency-many extra words, never past the block end
    n_exp = beats;
    if (unspec_q) n_exp = beats + int'(cas_latency) + int'(cas_half);
    if (unspec_q && n_exp > (ddr ? 4 : 8) - off) n_exp = (ddr ? 4 : 8) - off;
    e = exp_cmds(wr, ddr, sq, row_ok[bk] && open_row[bk] === row, row_ok[bk], beats, off, rf);
    mem_is_ddr <= ddr;
    push_n(wr ? beats - pre_n : 0);
    pre_n = 0;
    @(posedge clk_sys);
    seen.delete();
    n_rd = 0;
    n_ref = 0;
    req_valid <= 1'b1;
    req <= '{wr, sq, unspec_q, 5'(beats), {3'h0, row, bk, col}};
    t = 0;
    do begin @(posedge clk_sys); t++; end while (req_ready !== 1'b1 && t < 500);
    if (req_ready !== 1'b1) n_mismatch++;
    req_valid <= 1'b0;
    if (rf) refresh_req <= 1'b1;
    @(posedge clk_sys);
    refresh_req <= 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 3000) begin @(posedge clk_sys); t++; end
    if (busy !== 1'b0) n_mismatch++;
    repeat (settle) @(posedge clk_sys);
    g = '0;
    foreach (seen[i]) if (i < 7) g[i*3+:3] = seen[i];
    check(g, e);
    if (!wr) check(n_rd, n_exp);
    if (rf) check(n_ref, 1);
    row_ok[bk] = 1'b1;
    open_row[bk] = row;
  endtask : access

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(busy, 0);
    check(mem_pins.cmd, CMD_NOP);
    cmd_mode_field <= 3'h1;
    req_valid <= 1'b1;
    repeat (60) begin @(posedge clk_sys); check(req_ready, 0); end
    req_valid <= 1'b0;
    cmd_mode_field <= 3'h0;
    access(1, 0, 1, 2'h0, 13'h5, 14'h10, 1, 0);
    access(1, 1, 1, 2'h0, 13'h5, 14'h11, 1, 0);
    access(1, 0, 1, 2'h0, 13'h5, 14'h12, 1, 0);
    access(0, 0, 1, 2'h0, 13'h5, 14'h12, 1, 0);
    access(0, 1, 1, 2'h0, 13'h9, 14'h00, 1, 0);
    access(1, 1, 0, 2'h1, 13'h3, 14'h20, 1, 1);
    push_n(8);
    pre_n = 8;
    @(posedge clk_sys);
    check(wdata_ready, 0);
    access(1, 1, 0, 2'h1, 13'h3, 14'h28, 8, 0);
    check(wdata_ready, 1);
    // Read right behind a write must wait out the write recovery
    settle = 2;
    access(1, 1, 1, 2'h2, 13'h7, 14'h00, 1, 0);
    settle = 120;
    access(0, 1, 1, 2'h2, 13'h7, 14'h00, 1, 0);
    // Random single accesses over two rows and all banks
    for (int k = 0; k < 14; k++) begin
      int cl_pick;
      cl_pick = $random(seed) & 3;
      cas_latency <= (cl_pick < 2) ? 2'h2 : 2'h3;
      cas_half <= (cl_pick == 1);
      t_rp <= 4'h1 + 4'($unsigned($random(seed)) % 3);
      t_rcd <= 4'h1 + 4'($unsigned($random(seed)) % 3);
      access(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 2'($random(seed)),
             13'h1 + 13'($random(seed) & 1), 14'($random(seed)), 1, 0);
    end
    unspec_q = 1'b1;
    access(0, 0, 1, 2'h3, 13'h2, 14'h00, 1, 0);
    stop_test();
  end

  // Whole run is well under this span
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule : testbench
